/* rtl/buck_cfg_pkg.sv */
package buck_cfg_pkg;

    // register offsets on the management bus
    localparam logic [7:0]  CFG_TWO_OFS     = 8'h09;
    localparam logic [7:0]  VTH_OFS         = 8'h0A;

    // values after reset
    localparam logic [7:0]  CFG_TWO_RST     = 8'hF3;
    localparam logic [7:0]  VTH_RST         = 8'h32;
    localparam logic [2:0]  VTL_RST         = 3'h0;
    localparam logic [10:0] TARGET_RST      = 11'h190;
    localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;

    // field positions in converter_config_two
    localparam int RAMP_SEL_HI  = 7;
    localparam int RAMP_SEL_LO  = 6;
    localparam int DIS_RAMP_BIT = 5;
    localparam int DIS_OFF_BIT  = 4;
    localparam int UVP_OFF_BIT  = 3;
    localparam int LATCH_BIT    = 2;
    localparam int BIAS_BIT     = 1;
    localparam int AUX_BIT      = 0;

    // target code mapping
    localparam logic [10:0] SAT_CODE        = 11'h780;
    localparam logic [10:0] MIN_CHAR_CODE   = 11'h0F0;
    localparam logic [15:0] VOUT_HALF_MV    = 16'h0019;

    // ramp step timing
    localparam int CLK_MHZ       = 250;
    localparam int STEP_BASE_NS  = 1000;
    localparam int STEP_BASE_CYC = (STEP_BASE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [10:0] STEP_BASE_W = 11'(STEP_BASE_CYC);

    // management bus byte engine
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0]  LAST_TX_BIT     = 4'h7;

    typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} i2c_phase_t;

endpackage

/* rtl/buck_config_voltage_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// - config byte two is writable and readable
// - bits 7:6 pick step period x1..x8
// - bit5 discharges output while ramping down
// - bit4 discharges output while converter disabled
// - bit3 set turns undervoltage protection off
// - bit2 picks latch-off, else hiccup restart
// - bit1 auto-starts the bias converter
// - bit0 auto-starts the auxiliary regulator
// - upper target register is writable and readable
// - code is upper byte then three low bits
// - linear mapping, reset code gives five volts
// - reference saturates from code 0x780 upward
// - new code applies only on load command
module buck_config_voltage_regs
    import buck_cfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h25
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [2:0]  target_low_i,
    input  wire logic        apply_target_i,
    input  wire logic        main_enable_i,
    output logic [1:0]       ramp_step_sel_o,
    output logic             output_discharge_o,
    output logic             undervoltage_protect_on_o,
    output logic             fault_latch_off_o,
    output logic             bias_auto_start_o,
    output logic             auxiliary_regulator_auto_o,
    output logic [10:0]      voltage_target_code_o,
    output logic [10:0]      ramp_code_o,
    output logic             ramp_busy_o,
    output logic [10:0]      ref_code_o,
    output logic [15:0]      vout_half_mv_o
);

    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  vth;
        logic [10:0] target;
        logic [10:0] ramp;
        logic [10:0] tmr;
        logic        dis;
        logic        uvp_on;
        logic        busy;
        logic [10:0] refc;
        logic [15:0] vout;
    } top_st_t;

    top_st_t     q, d;
    logic [10:0] period_m1;
    logic [10:0] map_ref;
    logic [15:0] map_vout;
    logic        ramp_down;
    logic        cfg_we;
    logic        vth_we;

    reg_access_if rbus ();

    i2c_reg_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_o     (sda_o),
        .sda_oe_o  (sda_oe_o),
        .bus       (rbus.master)
    );

    target_code_map u_map (
        .code_i         (q.ramp),
        .ref_code_o     (map_ref),
        .vout_half_mv_o (map_vout)
    );

    // read decode; every other offset reads back as RDATA_UNMAPPED (zero)
    always_comb begin
        if (rbus.raddr == CFG_TWO_OFS) begin
            rbus.rdata = q.cfg;
        end else if (rbus.raddr == VTH_OFS) begin
            rbus.rdata = q.vth;
        end else begin
            rbus.rdata = RDATA_UNMAPPED;
        end
    end

    always_comb begin
        cfg_we = rbus.we && rbus.waddr == CFG_TWO_OFS;
        vth_we = rbus.we && rbus.waddr == VTH_OFS;
    end

    always_comb begin
        d         = q;
        period_m1 = 11'(STEP_BASE_W << q.cfg[RAMP_SEL_HI:RAMP_SEL_LO]) - 11'h001;
        ramp_down = q.ramp > q.target;
        if (cfg_we) begin
            d.cfg = rbus.wdata;
        end
        if (vth_we) begin
            d.vth = rbus.wdata;
        end
        // the host's write only stages the code; the load command commits it
        if (apply_target_i) begin
            d.target = {q.vth, target_low_i};
        end
        if (q.ramp == q.target) begin
            d.tmr = '0;
        end else if (q.tmr >= period_m1) begin
            d.tmr  = '0;
            d.ramp = ramp_down ? q.ramp - 11'h001 : q.ramp + 11'h001;
        end else begin
            d.tmr = q.tmr + 11'h001;
        end
        d.busy   = d.ramp != d.target;
        d.dis    = (q.cfg[DIS_OFF_BIT] && !main_enable_i)
                || (q.cfg[DIS_RAMP_BIT] && ramp_down);
        d.uvp_on = ~d.cfg[UVP_OFF_BIT];
        d.refc   = map_ref;
        d.vout   = map_vout;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{cfg: CFG_TWO_RST, vth: VTH_RST, target: TARGET_RST, ramp: TARGET_RST,
                   uvp_on: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign ramp_step_sel_o            = q.cfg[RAMP_SEL_HI:RAMP_SEL_LO];
    assign output_discharge_o         = q.dis;
    assign undervoltage_protect_on_o  = q.uvp_on;
    assign fault_latch_off_o          = q.cfg[LATCH_BIT];
    assign bias_auto_start_o          = q.cfg[BIAS_BIT];
    assign auxiliary_regulator_auto_o = q.cfg[AUX_BIT];
    assign voltage_target_code_o      = q.target;
    assign ramp_code_o                = q.ramp;
    assign ramp_busy_o                = q.busy;
    assign ref_code_o                 = q.refc;
    assign vout_half_mv_o             = q.vout;

    // low codes are passed through untouched; keeping above the
    // characterised floor is left to the host

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_cfg_write_lands: assert property (
        cfg_we |=> (q.cfg == $past(rbus.wdata)) && (rbus.raddr != CFG_TWO_OFS
                   || rbus.rdata == q.cfg))
        else $error("config byte two write not stored");

    a_vth_write_lands: assert property (
        vth_we |=> q.vth == $past(rbus.wdata))
        else $error("upper target write not stored");

    a_cfg_holds: assert property (
        !cfg_we |=> $stable(q.cfg))
        else $error("config byte two changed without a write");

    a_target_on_apply: assert property (
        apply_target_i |=> q.target == {$past(q.vth), $past(target_low_i)})
        else $error("target code not formed from both registers");

    a_target_waits_load: assert property (
        !apply_target_i |=> $stable(q.target))
        else $error("target code changed without load command");

    a_ramp_step_time: assert property (
        $changed(q.ramp) |-> $past(q.tmr) == ({8'h00, $past(STEP_BASE_W)} <<
            $past(q.cfg[RAMP_SEL_HI:RAMP_SEL_LO])) - 11'h001)
        else $error("ramp stepped at the wrong period");

    a_ramp_one_lsb: assert property (
        $changed(q.ramp) |-> (q.ramp == $past(q.ramp) + 11'h001)
                          || (q.ramp == $past(q.ramp) - 11'h001))
        else $error("ramp moved by more than one code");

    a_discharge_off: assert property (
        ($past(rst_n_i) && q.cfg[DIS_OFF_BIT] && !main_enable_i) |=> output_discharge_o)
        else $error("no discharge while converter disabled");

    a_discharge_ramp: assert property (
        (main_enable_i && (!q.cfg[DIS_RAMP_BIT] || q.ramp <= q.target)) |=> !output_discharge_o)
        else $error("discharge used outside a downward ramp");

    a_discharge_down: assert property (
        (q.cfg[DIS_RAMP_BIT] && q.ramp > q.target) |=> output_discharge_o)
        else $error("no discharge during downward ramp");

    a_uvp_follows: assert property (
        cfg_we |=> undervoltage_protect_on_o == !$past(rbus.wdata[UVP_OFF_BIT]))
        else $error("undervoltage protection does not follow bit 3");

    a_ref_saturates: assert property (
        ($past(rst_n_i) && $past(q.ramp) >= SAT_CODE) |-> q.refc == SAT_CODE)
        else $error("reference not saturated at full scale");

    a_vout_linear: assert property (
        ($past(rst_n_i) && $past(q.ramp) < SAT_CODE)
            |-> q.vout == 16'({5'h00, $past(q.ramp)} * VOUT_HALF_MV))
        else $error("output voltage map not linear");

endmodule // buck_config_voltage_regs

/* rtl/i2c_reg_slave.sv */
`timescale 1ns/1ps
module i2c_reg_slave
    import buck_cfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h25
) (
    input  wire logic     sys_clk_i,
    input  wire logic     rst_n_i,
    input  wire logic     scl_i,
    input  wire logic     sda_i,
    output logic          sda_o,
    output logic          sda_oe_o,
    reg_access_if.master  bus
);
    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} i2c_state_t;

    typedef struct packed {
        i2c_state_t st;
        i2c_phase_t ph;
        logic       scl_s1;
        logic       scl_s2;
        logic       scl_p;
        logic       sda_s1;
        logic       sda_s2;
        logic       sda_p;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic       rw;
        logic       nack;
        logic       oe;
        logic       we;
        logic [7:0] wa;
        logic [7:0] wd;
    } i2c_st_t;

    i2c_st_t q, d;
    logic    rise, fall, start, stop;

    always_comb begin
        d        = q;
        d.we     = 1'b0;
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_p  = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_p  = q.sda_s2;
        rise     = q.scl_s2 & ~q.scl_p;
        fall     = ~q.scl_s2 & q.scl_p;
        start    = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
        stop     = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
        if (start) begin
            d.st  = S_RX;
            d.ph  = PH_ADDR;
            d.cnt = '0;
            d.oe  = 1'b0;
        end else if (stop) begin
            d.st = S_IDLE;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                S_RX: begin
                    if (rise) begin
                        d.sh  = {q.sh[6:0], q.sda_s2};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == BITS_PER_BYTE) begin
                        d.cnt = '0;
                        d.oe  = 1'b1;
                        d.st  = S_ACK;
                        case (q.ph)
                            PH_ADDR: begin
                                if (q.sh[7:1] != DEV_ADDR) begin
                                    d.oe = 1'b0;
                                    d.st = S_IDLE;
                                end
                                d.rw = q.sh[0];
                            end
                            PH_PTR: d.ptr = q.sh;
                            default: begin
                                d.we  = 1'b1;
                                d.wa  = q.ptr;
                                d.wd  = q.sh;
                                d.ptr = q.ptr + 8'h01;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        d.cnt = '0;
                        if (q.ph == PH_ADDR && q.rw) begin
                            d.sh = bus.rdata;
                            d.oe = ~bus.rdata[7];
                            d.st = S_TX;
                        end else begin
                            d.oe = 1'b0;
                            d.st = S_RX;
                            d.ph = (q.ph == PH_ADDR) ? PH_PTR : PH_DATA;
                        end
                    end
                end
                S_TX: begin
                    if (fall) begin
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == LAST_TX_BIT) begin
                            d.oe  = 1'b0;
                            d.ptr = q.ptr + 8'h01;
                            d.st  = S_TXACK;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.oe = ~q.sh[6];
                        end
                    end
                end
                S_TXACK: begin
                    if (rise) begin
                        d.nack = q.sda_s2;
                    end else if (fall) begin
                        if (q.nack) begin
                            d.st = S_IDLE;
                        end else begin
                            d.sh  = bus.rdata;
                            d.oe  = ~bus.rdata[7];
                            d.cnt = '0;
                            d.st  = S_TX;
                        end
                    end
                end
                default: d.st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{st: S_IDLE, ph: PH_ADDR, scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
                   sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // open drain: the pin is only ever pulled low
    assign sda_o     = 1'b0;
    assign sda_oe_o  = q.oe;
    assign bus.we    = q.we;
    assign bus.waddr = q.wa;
    assign bus.wdata = q.wd;
    assign bus.raddr = q.ptr;
endmodule // i2c_reg_slave

/* rtl/reg_access_if.sv */
`timescale 1ns/1ps
interface reg_access_if;
    logic       we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;
    modport master (output we, waddr, wdata, raddr, input rdata);
    modport slave  (input we, waddr, wdata, raddr, output rdata);
endinterface

/* rtl/target_code_map.sv */
`timescale 1ns/1ps
module target_code_map
    import buck_cfg_pkg::*;
(
    input  wire logic [10:0] code_i,
    output logic      [10:0] ref_code_o,
    output logic      [15:0] vout_half_mv_o
);
    // codes from the saturation point upward all give full scale
    always_comb begin
        ref_code_o     = (code_i >= SAT_CODE) ? SAT_CODE : code_i;
        vout_half_mv_o = 16'({5'h00, ref_code_o} * VOUT_HALF_MV);
    end
endmodule // target_code_map

/* verif/buck_config_voltage_regs_bench.sv */
`timescale 1ns/1ps
module buck_config_voltage_regs_bench;
    import buck_cfg_pkg::*;
    logic        sys_clk, rst_n, main_enable, apply_target, scl, host_low, sda_out, sda_oe;
    logic [2:0]  target_low;
    logic [1:0]  step_sel;
    logic        discharge, uvp_on, latch_off, bias_auto, aux_auto, busy, ok_v;
    logic [10:0] target_code, ramp_code, ref_code;
    logic [15:0] vout;
    logic [7:0]  rd_v;
    logic [7:0]  cfg_tab [4] = '{8'h0C, 8'h53, 8'hA2, 8'hF1};
    logic [10:0] exp_ref;
    int          miscompares = 0;
    int          n_tests = 0;
    wire         sda_line = !(host_low || (sda_oe && !sda_out));

    always #2 sys_clk = ~sys_clk;

    buck_config_voltage_regs u_dut (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_out), .sda_oe_o(sda_oe), .target_low_i(target_low),
        .apply_target_i(apply_target), .main_enable_i(main_enable),
        .ramp_step_sel_o(step_sel), .output_discharge_o(discharge),
        .undervoltage_protect_on_o(uvp_on), .fault_latch_off_o(latch_off),
        .bias_auto_start_o(bias_auto), .auxiliary_regulator_auto_o(aux_auto),
        .voltage_target_code_o(target_code), .ramp_code_o(ramp_code),
        .ramp_busy_o(busy), .ref_code_o(ref_code), .vout_half_mv_o(vout));
    i2c_host_model u_host (.sys_clk_i(sys_clk), .sda_i(sda_line), .scl_o(scl),
                           .sda_low_o(host_low));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_fields(input logic [7:0] c);
        chk(16'(step_sel), 16'(c[7:6]));
        chk(16'(uvp_on), 16'(!c[3]));
        chk(16'(latch_off), 16'(c[2]));
        chk(16'(bias_auto), 16'(c[1]));
        chk(16'(aux_auto), 16'(c[0]));
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        u_host.reg_read(ofs, rd_v, ok_v);
        chk(16'(ok_v), 16'h0001);
        chk(16'(rd_v), 16'(exp));
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [15:0] d, input logic two);
        u_host.reg_write(ofs, d, two, ok_v);
        chk(16'(ok_v), 16'h0001);
    endtask

    // apply pulse then let the committed code land
    task automatic pulse_apply();
        apply_target <= 1'b1;
        @(posedge sys_clk);
        apply_target <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        main_enable = 1'b0;
        apply_target = 1'b0;
        target_low = 3'h0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk_fields(8'hF3);
        chk(16'(target_code), 16'h0190);
        chk(vout, 16'h2710);
        chk(16'(discharge), 16'h0001);
        rd(8'h09, 8'hF3);
        rd(8'h0A, 8'h32);
        for (int i = 0; i < 4; i++) begin
            wr(8'h09, 16'(cfg_tab[i]), 1'b0);
            rd(8'h09, cfg_tab[i]);
            chk_fields(cfg_tab[i]);
            chk(16'(discharge), 16'(cfg_tab[i][4]));
        end
        main_enable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(16'(discharge), 16'h0000);
        // unmapped offsets are acked but hold nothing
        wr(8'h0C, 16'h005A, 1'b0);
        rd(8'h0B, 8'h00);
        rd(8'h09, 8'hF1);
        // code 0x18D, above the lowest characterised point
        target_low <= 3'h5;
        wr(8'h09, 16'h2031, 1'b1);
        rd(8'h0A, 8'h31);
        chk(16'(target_code), 16'h0190);
        pulse_apply();
        @(posedge sys_clk);
        chk(16'(target_code), 16'h018D);
        chk(16'(discharge), 16'h0001);
        chk(16'(busy), 16'h0001);
        repeat (240) @(posedge sys_clk);
        chk(16'(ramp_code), 16'h0190);
        repeat (20) @(posedge sys_clk);
        chk(16'(ramp_code), 16'h018F);
        for (int n = 0; n < 1000 && busy !== 1'b0; n++) begin
            @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
        chk(16'(ramp_code), 16'h018D);
        chk(16'(ref_code), 16'h018D);
        chk(vout, 16'h26C5);
        chk(16'(discharge), 16'h0000);
        // ramping down without the discharge bit keeps the resistor off
        target_low <= 3'h0;
        wr(8'h09, 16'h0000, 1'b0);
        pulse_apply();
        repeat (3) @(posedge sys_clk);
        chk(16'(busy), 16'h0001);
        chk(16'(discharge), 16'h0000);
        // full scale is too many steps away to ramp to within the run
        for (int n = 0; n < 2000 && busy !== 1'b0; n++) begin
            @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
        exp_ref = (11'h188 < 11'h780) ? 11'h188 : 11'h780;
        chk(16'(ramp_code), 16'h0188);
        chk(16'(ref_code), 16'(exp_ref));
        chk(vout, 16'(exp_ref) * 16'h0019);
        end_sim();
    end
endmodule // buck_config_voltage_regs_bench

/* verif/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h25,
    parameter int         HALF     = 8
) (
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // both lines released; pull-ups hold them high between frames
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic hold();
        repeat (HALF) @(posedge sys_clk_i);
    endtask

    // doubles as repeated start: data released while clock still low
    task automatic start();
        sda_low_o <= 1'b0;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_low_o <= 1'b1;
        hold();
        scl_o <= 1'b0;
        hold();
    endtask

    task automatic stop();
        sda_low_o <= 1'b1;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_low_o <= 1'b0;
        hold();
    endtask

    // data moves only mid-low, so the slave never sees it change under a high clock
    task automatic bit_xfer(input logic b, output logic seen);
        sda_low_o <= ~b;
        hold();
        scl_o <= 1'b1;
        hold();
        seen = sda_i;
        scl_o <= 1'b0;
        hold();
    endtask

    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(v[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    task automatic byte_in(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            v[i] = s;
        end
        bit_xfer(last, s);
    endtask

    task automatic reg_write(input logic [7:0] ofs, input logic [15:0] d, input logic two,
                             output logic ok);
        logic a0, a1, a2, a3;
        a3 = 1'b1;
        start();
        byte_out({DEV_ADDR, 1'b0}, a0);
        byte_out(ofs, a1);
        if (two) begin
            byte_out(d[15:8], a3);
        end
        byte_out(d[7:0], a2);
        stop();
        ok = a0 & a1 & a2 & a3;
    endtask

    task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        byte_out({DEV_ADDR, 1'b0}, a0);
        byte_out(ofs, a1);
        start();
        byte_out({DEV_ADDR, 1'b1}, a2);
        byte_in(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // i2c_host_model
